/* File: design/alsc_conv.sv */
`timescale 1ns/10ps
module alsc_conv
  import alsc_pkg::*;
#(
  parameter int PERIOD_CYC = ALSC_CONV_PERIOD_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   sensor_en,
  input  wire logic [ALSC_CONV_W-1:0] light_sensor_input,
  output logic      [ALSC_CONV_W-1:0] conv_q,
  output logic                        conv_valid_q
);

  logic [ALSC_CNT_W-1:0] cnt_q;
  logic [ALSC_CNT_W-1:0] gap_q;

  // Refresh the conversion once per period while enabled
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q        <= '0;
      conv_q       <= '0;
      conv_valid_q <= 1'b0;
    end else if (!sensor_en) begin
      cnt_q        <= '0;
      conv_valid_q <= 1'b0;
    end else if (cnt_q == ALSC_CNT_W'(PERIOD_CYC - 1)) begin
      cnt_q        <= '0;
      conv_q       <= light_sensor_input;
      conv_valid_q <= 1'b1;
    end else begin
      cnt_q        <= cnt_q + 1'b1;
      conv_valid_q <= 1'b0;
    end
  end

  // Cycles since the last refresh, for checking only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= '0;
    end else if (!sensor_en) begin
      gap_q <= '0;
    end else if (conv_valid_q) begin
      gap_q <= ALSC_CNT_W'(1'b1); // Pulse cycle opens the next period
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_conv_sample: assert property (
    conv_valid_q |-> conv_q == $past(light_sensor_input))
    else $error("conversion does not hold the sampled input");

  a_conv_period: assert property (
    $rose(conv_valid_q) && $past(sensor_en, 2) && $past(gap_q) != '0
      |-> $past(gap_q) == ALSC_CNT_W'(PERIOD_CYC - 1))
    else $error("conversion refresh period wrong");

endmodule

/* File: design/alsc_pkg.sv */
package alsc_pkg;

  // Register offsets, reset value and unmapped read value
  localparam logic [7:0] ALSC_OFFICE_TRP_ADDR = 8'h1D;
  localparam logic [7:0] ALSC_OFFICE_HYS_ADDR = 8'h1E;
  localparam logic [7:0] ALSC_DARK_TRP_ADDR   = 8'h1F;
  localparam logic [7:0] ALSC_DARK_HYS_ADDR   = 8'h20;
  localparam logic [7:0] ALSC_REG_RESET       = 8'h00;
  localparam logic [7:0] ALSC_RD_UNMAPPED     = 8'h00;

  // Widths
  localparam int ALSC_CONV_W = 13;
  localparam int ALSC_CUR_W  = 24;
  localparam int ALSC_CNT_W  = 25;

  // Current steps in nanoamps
  localparam logic [ALSC_CUR_W-1:0] ALSC_OFFICE_STEP_NA = 24'h0010CC;
  localparam logic [ALSC_CUR_W-1:0] ALSC_DARK_STEP_NA   = 24'h00021C;
  localparam logic [ALSC_CUR_W-1:0] ALSC_CONV_LSB_NA    = 24'h00021C;

  // Conversion refresh time
  localparam int ALSC_CONV_PERIOD_MS = 80;
  localparam int ALSC_CLK_KHZ        = 250000;
  localparam int ALSC_CONV_PERIOD_CYC = ALSC_CONV_PERIOD_MS * ALSC_CLK_KHZ;

  typedef enum logic [1:0] {
    ALSC_DAYLIGHT,
    ALSC_OFFICE,
    ALSC_DARK
  } alsc_level_e;

  // Code times step, in nanoamps
  function automatic logic [ALSC_CUR_W-1:0] alsc_scale(input logic [15:0]           code,
                                                       input logic [ALSC_CUR_W-1:0] step);
    logic [ALSC_CUR_W+15:0] prod;
    prod = code * step;
    return prod[ALSC_CUR_W-1:0];
  endfunction

endpackage

/* File: design/alsc_top.sv */
`timescale 1ns/10ps
// What this block does
// - Office trip flag sets when current falls below office threshold.
// - Office threshold code is linear current, 4.3 uA per code.
// - Office flag clears when current exceeds office threshold plus hysteresis.
// - Office hysteresis code is current in 4.3 uA steps.
// - Dark trip flag sets when current falls below dark threshold.
// - Dark threshold code is current in 0.54 uA steps.
// - With both enabled and tripped, dark level wins over office.
// - Leaving dark when current exceeds dark threshold plus dark hysteresis.
// - Thirteen-bit conversion refreshed every 80 ms while sensor enabled.
module alsc_top
  import alsc_pkg::*;
#(
  parameter int CONV_PERIOD_CYC = ALSC_CONV_PERIOD_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata_q,
  input  wire logic                   sensor_en,
  input  wire logic                   office_cmp_en,
  input  wire logic                   dark_cmp_en,
  input  wire logic [ALSC_CONV_W-1:0] light_sensor_input,
  output logic                        office_trip_q,
  output logic                        dark_trip_q,
  output alsc_level_e                 backlight_level_q
);

  logic [7:0]             office_entry_threshold_q;
  logic [7:0]             office_exit_hysteresis_q;
  logic [7:0]             dark_entry_threshold_q;
  logic [7:0]             dark_exit_hysteresis_q;
  logic [ALSC_CONV_W-1:0] conv_q;
  logic                   conv_valid_q;
  logic [ALSC_CUR_W-1:0]  cur_na;
  logic [ALSC_CUR_W-1:0]  office_trp_na;
  logic [ALSC_CUR_W-1:0]  office_exit_na;
  logic [ALSC_CUR_W-1:0]  dark_trp_na;
  logic [ALSC_CUR_W-1:0]  dark_exit_na;
  alsc_level_e            level_d;

  alsc_conv #(
    .PERIOD_CYC (CONV_PERIOD_CYC)
  ) u_conv (
    .ref_clk            (ref_clk),
    .rstn               (rstn),
    .sensor_en          (sensor_en),
    .light_sensor_input (light_sensor_input),
    .conv_q             (conv_q),
    .conv_valid_q       (conv_valid_q)
  );

  // Register writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      office_entry_threshold_q <= ALSC_REG_RESET;
      office_exit_hysteresis_q <= ALSC_REG_RESET;
      dark_entry_threshold_q   <= ALSC_REG_RESET;
      dark_exit_hysteresis_q   <= ALSC_REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ALSC_OFFICE_TRP_ADDR) begin
        office_entry_threshold_q <= reg_wdata;
      end else if (reg_addr == ALSC_OFFICE_HYS_ADDR) begin
        office_exit_hysteresis_q <= reg_wdata;
      end else if (reg_addr == ALSC_DARK_TRP_ADDR) begin
        dark_entry_threshold_q <= reg_wdata;
      end else if (reg_addr == ALSC_DARK_HYS_ADDR) begin
        dark_exit_hysteresis_q <= reg_wdata;
      end
    end
  end

  // Registered read data, unmapped reads as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= ALSC_RD_UNMAPPED;
    end else if (reg_addr == ALSC_OFFICE_TRP_ADDR) begin
      reg_rdata_q <= office_entry_threshold_q;
    end else if (reg_addr == ALSC_OFFICE_HYS_ADDR) begin
      reg_rdata_q <= office_exit_hysteresis_q;
    end else if (reg_addr == ALSC_DARK_TRP_ADDR) begin
      reg_rdata_q <= dark_entry_threshold_q;
    end else if (reg_addr == ALSC_DARK_HYS_ADDR) begin
      reg_rdata_q <= dark_exit_hysteresis_q;
    end else begin
      reg_rdata_q <= ALSC_RD_UNMAPPED;
    end
  end

  // All levels compared in nanoamps
  always_comb begin
    cur_na         = alsc_scale({3'h0, conv_q}, ALSC_CONV_LSB_NA);
    office_trp_na  = alsc_scale({8'h00, office_entry_threshold_q}, ALSC_OFFICE_STEP_NA);
    office_exit_na = office_trp_na
                   + alsc_scale({8'h00, office_exit_hysteresis_q}, ALSC_OFFICE_STEP_NA);
    dark_trp_na    = alsc_scale({8'h00, dark_entry_threshold_q}, ALSC_DARK_STEP_NA);
    dark_exit_na   = dark_trp_na
                   + alsc_scale({8'h00, dark_exit_hysteresis_q}, ALSC_DARK_STEP_NA);
  end

  // Office comparator with hysteresis; host keeps codes in range
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      office_trip_q <= 1'b0;
    end else if (conv_valid_q) begin
      if (cur_na < office_trp_na) begin
        office_trip_q <= 1'b1;
      end else if (cur_na > office_exit_na) begin
        office_trip_q <= 1'b0;
      end
    end
  end

  // Dark comparator with hysteresis
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dark_trip_q <= 1'b0;
    end else if (conv_valid_q) begin
      if (cur_na < dark_trp_na) begin
        dark_trip_q <= 1'b1;
      end else if (cur_na > dark_exit_na) begin
        dark_trip_q <= 1'b0;
      end
    end
  end

  // Level select; inside a band the flags hold, so does the level
  always_comb begin
    if (dark_cmp_en && dark_trip_q) begin
      level_d = ALSC_DARK;
    end else if (office_cmp_en && office_trip_q) begin
      level_d = ALSC_OFFICE;
    end else begin
      level_d = ALSC_DAYLIGHT;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      backlight_level_q <= ALSC_DAYLIGHT;
    end else begin
      backlight_level_q <= level_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_office_below;
    conv_valid_q && cur_na < office_trp_na;
  endsequence

  sequence s_office_above;
    conv_valid_q && cur_na > office_exit_na;
  endsequence

  sequence s_dark_above;
    conv_valid_q && cur_na > dark_exit_na;
  endsequence

  a_office_entry: assert property (
    s_office_below ##1 (office_cmp_en && !dark_cmp_en)
      |=> backlight_level_q == ALSC_OFFICE)
    else $error("office level not entered below threshold");

  a_office_exit: assert property (
    s_office_above ##1 (office_cmp_en && !dark_cmp_en)
      |=> backlight_level_q == ALSC_DAYLIGHT)
    else $error("daylight level not entered above office band");

  a_office_hold: assert property (
    conv_valid_q && cur_na >= office_trp_na && cur_na <= office_exit_na
      |=> $stable(office_trip_q))
    else $error("office flag moved inside its band");

  a_dark_entry: assert property (
    conv_valid_q && cur_na < dark_trp_na |=> dark_trip_q)
    else $error("dark flag not set below threshold");

  a_dark_exit: assert property (
    conv_valid_q && cur_na > dark_exit_na |=> !dark_trip_q)
    else $error("dark flag not cleared above dark band");

  a_dark_priority: assert property (
    dark_cmp_en && dark_trip_q && office_cmp_en && office_trip_q
      |=> backlight_level_q == ALSC_DARK)
    else $error("dark level lost priority");

  a_office_scale: assert property (
    office_entry_threshold_q == 8'h01 |-> office_trp_na == ALSC_OFFICE_STEP_NA)
    else $error("office threshold scale wrong");

  a_hys_scale: assert property (
    office_entry_threshold_q == 8'h00 && office_exit_hysteresis_q == 8'h02
      |-> office_exit_na == 24'h002198)
    else $error("office hysteresis scale wrong");

  a_dark_scale: assert property (
    dark_entry_threshold_q == 8'hFF |-> dark_trp_na == 24'h0219E4)
    else $error("dark threshold scale wrong");

  a_dark_hold: assert property (
    conv_valid_q && cur_na >= dark_trp_na && cur_na <= dark_exit_na
      |=> $stable(dark_trip_q))
    else $error("dark flag moved inside its band");

  a_dark_to_office: assert property (
    s_dark_above ##1 (office_cmp_en && office_trip_q)
      |=> backlight_level_q == ALSC_OFFICE)
    else $error("office level not entered above dark band");

  a_level_none: assert property (
    !office_cmp_en && !dark_cmp_en |=> backlight_level_q == ALSC_DAYLIGHT)
    else $error("level left daylight with comparators off");

  a_office_write: assert property (
    reg_wr && reg_addr == ALSC_OFFICE_TRP_ADDR
      |=> office_entry_threshold_q == $past(reg_wdata))
    else $error("office threshold write lost");

  a_dark_write: assert property (
    reg_wr && reg_addr == ALSC_DARK_TRP_ADDR
      |=> dark_entry_threshold_q == $past(reg_wdata))
    else $error("dark threshold write lost");

endmodule

/* File: tb/alsc_sensor_model.sv */
`timescale 1ns/10ps
// Photosensor conversion source; new code lands just after a clock edge
module alsc_sensor_model
  import alsc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic [ALSC_CONV_W-1:0] level_code,
  output logic      [ALSC_CONV_W-1:0] light_sensor_input
);
  initial light_sensor_input = '0;
  always @(posedge ref_clk) begin
    light_sensor_input <= #1 level_code;
  end
endmodule

/* File: tb/ambient_light_level_compare_bench.sv */
`timescale 1ns/10ps
module ambient_light_level_compare_bench
  import alsc_pkg::*;
;
  logic                   ref_clk;
  logic                   rstn;
  logic [7:0]             reg_addr;
  logic                   reg_wr;
  logic [7:0]             reg_wdata;
  logic [7:0]             reg_rdata_q;
  logic                   sensor_en;
  logic                   office_cmp_en;
  logic                   dark_cmp_en;
  logic [ALSC_CONV_W-1:0] level_code;
  logic [ALSC_CONV_W-1:0] light_sensor_input;
  logic                   office_trip_q;
  logic                   dark_trip_q;
  alsc_level_e            backlight_level_q;
  logic [7:0]             rq[$];
  logic [3:0]             lq[$];
  logic                   of_e;
  logic                   df_e;
  int                     miscompares;
  int                     comparisons;
  int                     thr[4];
  int                     seq[7] = '{100, 200, 250, 200, 40, 60, 80};
  event                   rd_ev;
  event                   lv_ev;

  alsc_top #(.CONV_PERIOD_CYC(16)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .sensor_en(sensor_en),
    .office_cmp_en(office_cmp_en), .dark_cmp_en(dark_cmp_en),
    .light_sensor_input(light_sensor_input), .office_trip_q(office_trip_q),
    .dark_trip_q(dark_trip_q), .backlight_level_q(backlight_level_q)
  );
  alsc_sensor_model sensor_u (
    .ref_clk(ref_clk), .level_code(level_code), .light_sensor_input(light_sensor_input)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t read got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_lvl(input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t flags/level got %h exp %h", $time, g, e);
    end
  endtask

  always @(rd_ev) cmp_rd(rq.pop_front(), reg_rdata_q);
  always @(lv_ev) cmp_lvl(lq.pop_front(), {office_trip_q, dark_trip_q, backlight_level_q});

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) #1;
    reg_addr = a;
    rq.push_back(e);
    @(posedge ref_clk) #1;
    ->rd_ev;
  endtask

  // Expected flags from codes in nanoamps, then level with dark first
  task automatic note_level();
    logic [1:0] lv;
    lv = (dark_cmp_en && df_e) ? 2'h2 : (office_cmp_en && of_e) ? 2'h1 : 2'h0;
    lq.push_back({of_e, df_e, lv});
    ->lv_ev;
  endtask

  task automatic sense(input int v);
    int cur;
    level_code = v[ALSC_CONV_W-1:0];
    sensor_en = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1;
    cur = v * 540;
    if (cur < thr[0] * 4300) of_e = 1'b1;
    else if (cur > (thr[0] + thr[1]) * 4300) of_e = 1'b0;
    if (cur < thr[2] * 540) df_e = 1'b1;
    else if (cur > (thr[2] + thr[3]) * 540) df_e = 1'b0;
    note_level();
  endtask

  initial begin
    void'($urandom(32'h3219));
    {reg_addr, reg_wr, reg_wdata, sensor_en, office_cmp_en, dark_cmp_en} = '0;
    {level_code, of_e, df_e} = '0;
    rstn = 1'b0;
    thr = '{20, 10, 50, 20};
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 5; i++) rd(8'h1D + i[7:0], 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h1D + i[7:0], thr[i][7:0]);
    wr(8'h21, 8'h5A);
    for (int i = 0; i < 4; i++) rd(8'h1D + i[7:0], thr[i][7:0]);
    rd(8'h21, 8'h00);
    office_cmp_en = 1'b1;
    dark_cmp_en = 1'b1;
    foreach (seq[i]) sense(seq[i]);
    sense(30);
    @(posedge ref_clk) #1 dark_cmp_en = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 note_level();
    office_cmp_en = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 note_level();
    office_cmp_en = 1'b1;
    dark_cmp_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      thr[0] = $urandom_range(0, 200);
      thr[1] = $urandom_range(0, 250 - thr[0]);
      thr[2] = $urandom_range(0, 255);
      thr[3] = $urandom_range(0, 255);
      // Sensor off while thresholds change, so no conversion sees a half-written set
      sensor_en = 1'b0;
      for (int i = 0; i < 4; i++) wr(8'h1D + i[7:0], thr[i][7:0]);
      sense($urandom_range(0, 2100));
    end
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
endmodule
